// ### hw/acr_pkg.sv
// constants for the converter configuration register block
package acr_pkg;
	// byte lanes of the 24-bit result and 32-bit configuration registers, by byte index within the serial address map
	localparam logic [3:0] ADDR_OUT_B2  = 4'h0;
	localparam logic [3:0] ADDR_OUT_B1  = 4'h1;
	localparam logic [3:0] ADDR_OUT_B0  = 4'h2;
	localparam logic [3:0] ADDR_CFG_B3  = 4'h4;
	localparam logic [3:0] ADDR_CFG_B2  = 4'h5;
	localparam logic [3:0] ADDR_CFG_B1  = 4'h6;
	localparam logic [3:0] ADDR_CFG_B0  = 4'h7;
	// top byte bit positions
	localparam int BIT_BIAS   = 31;
	localparam int BIT_REF_OUT = 30;
	localparam int BIT_FMT    = 29;
	localparam int BIT_UNIP   = 28;
	localparam int BIT_BORD   = 27;
	localparam int BIT_BITORD = 26;
	localparam int BIT_PINSEL = 25;
	localparam int BIT_READY  = 24;
	// field positions
	localparam int MODE_LSB   = 21;
	localparam int GAIN_LSB   = 18;
	localparam int CHAN_LSB   = 16;
	localparam int RATE_LSB   = 13;
	localparam int DEC_LSB    = 0;
	// reset value: reference on, decimation 23, everything else zero
	localparam logic [31:0] CFG_RESET = 32'h4000_0017;
	// mode codes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_BGCAL  = 3'h5;
	localparam logic [2:0] MODE_SLEEP  = 3'h6;
	// invalid results after a channel change
	localparam logic [1:0] CHAN_SKIP   = 2'h3;
	// instruction byte fields
	localparam int INS_RW     = 7;
	localparam int INS_MB_LSB = 5;
endpackage

// ### hw/acr_edge.sv
// two-flop synchroniser with edge detection for link pins
`timescale 1ns/100ps
module acr_edge #(
	parameter logic IDLE = 1'b0
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// pin in
	input  wire logic pin,
	// synchronised level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= IDLE;
			sync_reg <= IDLE;
			last_reg <= IDLE;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;
endmodule

// ### hw/acr_config.sv
// converter configuration register with its serial access engine
// What this block does
// - each written byte takes effect on the falling clock of its last bit
// - four bytes: control flags, mode/gain/channel, rate and decimation
// - reset gives reference on, decimation 23, all other fields zero
// - bias bit enables the bias generator when one, off by default
// - reference bit drives reference output when one, high impedance when zero
// - format bit picks two's complement at zero, offset binary at one
// - format change only inverts result msb, only in the result register
// - unipolar bit clamps negative results to zero
// - clamp acts on result register only; clearing gives bipolar next result
// - byte-order bit makes reads step downward from the start address
// - bit-order bit shifts read bytes lsb first; writes unaffected
// - pin-select zero uses shared pin, one uses dedicated output pin
// - ready bit reads the live result-ready pin; writes ignored
// - writing one to ready position pulses modulator resync
// - mode field codes normal to sleep, code seven reserved
// - normal, background and sleep persist; others return to normal
// - channel change marks the next three results invalid
`timescale 1ns/100ps
module acr_config (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// serial link pins
	input  wire logic        serial_clk,
	input  wire logic        chip_select_n,
	input  wire logic        shared_data_in,
	output logic             shared_data_out,
	output logic             shared_data_oe,
	output logic             dedicated_output_pin,
	output logic             dedicated_output_oe,
	// converter core
	input  wire logic        result_ready_n,
	input  wire logic        result_load,
	input  wire logic [23:0] raw_result,
	input  wire logic        action_done,
	output logic             modulator_resync,
	output logic             result_valid,
	// configuration outputs
	output logic             bias_enable,
	output logic             reference_output_enable,
	output logic [2:0]       operating_mode_field,
	output logic [2:0]       gain_field,
	output logic [1:0]       channel_field,
	output logic [2:0]       rate_multiplier_field,
	output logic [12:0]      decimation_field
);
	typedef enum logic [1:0] {ACR_IDLE, ACR_INSTR, ACR_DATA} acr_state_e;

	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_lvl;
	logic        cs_rise;
	logic        cs_fall;
	logic        din_lvl;
	logic        rdy_lvl;
	logic        rdy_fall;

	// link clock edges, idle low
	acr_edge u_sclk (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pin     (serial_clk),
		.level   (),
		.rise    (sclk_rise),
		.fall    (sclk_fall)
	);
	// frame select, idle high so reset gives no false edge
	acr_edge #(
		.IDLE (1'b1)
	) u_cs (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pin     (chip_select_n),
		.level   (cs_lvl),
		.rise    (cs_rise),
		.fall    (cs_fall)
	);
	// host data in
	acr_edge u_din (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pin     (shared_data_in),
		.level   (din_lvl),
		.rise    (),
		.fall    ()
	);
	// core ready pin, idle high
	acr_edge #(
		.IDLE (1'b1)
	) u_rdy (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pin     (result_ready_n),
		.level   (rdy_lvl),
		.rise    (),
		.fall    (rdy_fall)
	);

	acr_state_e  state_reg, state_next;
	logic [31:0] cfg_reg;
	logic [7:0]  shift_reg;
	logic [2:0]  bit_reg;
	logic [3:0]  addr_reg;
	logic [1:0]  left_reg;
	logic        rd_reg;
	logic [7:0]  tx_reg;
	logic [23:0] out_reg;
	logic [1:0]  skip_reg;
	logic        resync_reg;
	logic        dout_reg;

	// byte of the register map at an address
	function automatic logic [7:0] map_byte(
		input logic [3:0]  a,
		input logic [31:0] c,
		input logic [23:0] o,
		input logic        rdy
	);
		logic [31:0] live;
		live = c;
		live[acr_pkg::BIT_READY] = rdy;
		case (a)
			acr_pkg::ADDR_OUT_B2: map_byte = o[23:16];
			acr_pkg::ADDR_OUT_B1: map_byte = o[15:8];
			acr_pkg::ADDR_OUT_B0: map_byte = o[7:0];
			acr_pkg::ADDR_CFG_B3: map_byte = live[31:24];
			acr_pkg::ADDR_CFG_B2: map_byte = live[23:16];
			acr_pkg::ADDR_CFG_B1: map_byte = live[15:8];
			acr_pkg::ADDR_CFG_B0: map_byte = live[7:0];
			default:              map_byte = 8'h00;
		endcase
	endfunction

	// modes that finish an action and then fall back to normal
	function automatic logic mode_is_temporary(input logic [2:0] m);
		case (m)
			acr_pkg::MODE_NORMAL: mode_is_temporary = 1'b0;
			acr_pkg::MODE_BGCAL:  mode_is_temporary = 1'b0;
			acr_pkg::MODE_SLEEP:  mode_is_temporary = 1'b0;
			default:              mode_is_temporary = 1'b1;
		endcase
	endfunction

	wire         bit_done   = sclk_fall && !cs_lvl && state_reg != ACR_IDLE;
	wire [7:0]   rx_byte    = {shift_reg[6:0], din_lvl};
	wire         byte_done  = bit_done && bit_reg == 3'h7;
	wire         is_instr   = state_reg == ACR_INSTR;
	wire         wr_byte    = byte_done && !is_instr && !rd_reg;
	wire         rd_step    = byte_done && !is_instr;
	wire         lsb_first  = cfg_reg[acr_pkg::BIT_BITORD];
	wire         step_down  = cfg_reg[acr_pkg::BIT_BORD];
	wire         pin_sel    = cfg_reg[acr_pkg::BIT_PINSEL];
	wire         cfg_hit    = addr_reg >= acr_pkg::ADDR_CFG_B3 &&
		addr_reg <= acr_pkg::ADDR_CFG_B0;
	wire [1:0]   lane       = 2'(acr_pkg::ADDR_CFG_B0 - addr_reg);
	wire         wr_top     = wr_byte && cfg_hit && lane == 2'h3;
	wire         wr_mgc     = wr_byte && cfg_hit && lane == 2'h2;
	wire         chan_new   = wr_mgc && rx_byte[1:0] != cfg_reg[acr_pkg::CHAN_LSB +: 2];
	wire [3:0]   first_addr = rx_byte[3:0];
	wire [3:0]   next_addr  = step_down ? addr_reg - 4'h1 : addr_reg + 4'h1;
	wire [3:0]   load_addr  = is_instr ? first_addr : next_addr;
	wire [7:0]   load_byte  = map_byte(load_addr, cfg_reg, out_reg, rdy_lvl);
	wire         mode_temp  = mode_is_temporary(cfg_reg[acr_pkg::MODE_LSB +: 3]);
	wire         load_tx    = byte_done && (is_instr ? rx_byte[acr_pkg::INS_RW] : rd_reg);
	// result formatting
	wire         unipolar   = cfg_reg[acr_pkg::BIT_UNIP];
	wire         raw_neg    = raw_result[23];
	wire [23:0]  clamped    = (unipolar && raw_neg) ? 24'h000000 : raw_result;
	wire         top_bit    = clamped[23] ^ cfg_reg[acr_pkg::BIT_FMT];
	wire [23:0]  formatted  = {top_bit, clamped[22:0]};

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ACR_IDLE:  if (cs_fall) state_next = ACR_INSTR;
			ACR_INSTR: if (byte_done) state_next = ACR_DATA;
			ACR_DATA:  if (byte_done && left_reg == 2'h0) state_next = ACR_IDLE;
			default:   state_next = ACR_IDLE;
		endcase
		if (cs_rise) state_next = ACR_IDLE;
	end

	// frame state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ACR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// bit counter, cleared at both frame edges
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bit_reg <= 3'h0;
		end else if (cs_fall || cs_rise) begin
			bit_reg <= 3'h0;
		end else if (bit_done) begin
			bit_reg <= bit_reg + 3'h1;
		end
	end

	// input shifter, always msb first
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= 8'h00;
		end else if (bit_done) begin
			shift_reg <= rx_byte;
		end
	end

	// instruction decode and address stepping
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_reg   <= 1'b0;
			left_reg <= 2'h0;
			addr_reg <= 4'h0;
		end else if (byte_done && is_instr) begin
			rd_reg   <= rx_byte[acr_pkg::INS_RW];
			left_reg <= rx_byte[acr_pkg::INS_MB_LSB +: 2];
			addr_reg <= first_addr;
		end else if (rd_step) begin
			left_reg <= left_reg - 2'h1;
			addr_reg <= rd_reg ? next_addr : addr_reg + 4'h1;
		end
	end

	// output shifter, loaded at each byte end of a read frame, shifted on rising link clock
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_reg <= 8'h00;
		end else if (load_tx) begin
			tx_reg <= load_byte;
		end else if (sclk_rise && rd_reg && !is_instr) begin
			tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
		end
	end

	// configuration register, each byte committed when its last bit falls
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= acr_pkg::CFG_RESET;
		end else begin
			if (mode_temp && action_done)
				cfg_reg[acr_pkg::MODE_LSB +: 3] <= acr_pkg::MODE_NORMAL;
			if (wr_byte && cfg_hit)
				cfg_reg[lane*8 +: 8] <= rx_byte;
			if (wr_top)
				cfg_reg[acr_pkg::BIT_READY] <= 1'b0;
		end
	end

	// one-cycle resync pulse from a one in the top byte's lowest bit
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			resync_reg <= 1'b0;
		end else begin
			resync_reg <= wr_top && rx_byte[0];
		end
	end

	// result register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			out_reg <= 24'h000000;
		end else if (result_load) begin
			out_reg <= formatted;
		end
	end

	// channel-change validity, a new change wins over a ready fall
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			skip_reg <= 2'h0;
		end else if (chan_new) begin
			skip_reg <= acr_pkg::CHAN_SKIP;
		end else if (rdy_fall && skip_reg != 2'h0) begin
			skip_reg <= skip_reg - 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) dout_reg <= 1'b0;
		else dout_reg <= lsb_first ? tx_reg[0] : tx_reg[7];
	end

	// pin steering
	wire driving = rd_reg && state_reg == ACR_DATA && !cs_lvl;
	assign shared_data_out         = dout_reg;
	assign shared_data_oe          = driving && !pin_sel;
	assign dedicated_output_pin    = dout_reg;
	assign dedicated_output_oe     = driving && pin_sel;
	assign modulator_resync        = resync_reg;
	assign result_valid            = skip_reg == 2'h0;
	assign bias_enable             = cfg_reg[acr_pkg::BIT_BIAS];
	assign reference_output_enable = cfg_reg[acr_pkg::BIT_REF_OUT];
	assign operating_mode_field    = cfg_reg[acr_pkg::MODE_LSB +: 3];
	assign gain_field              = cfg_reg[acr_pkg::GAIN_LSB +: 3];
	assign channel_field           = cfg_reg[acr_pkg::CHAN_LSB +: 2];
	assign rate_multiplier_field   = cfg_reg[acr_pkg::RATE_LSB +: 3];
	assign decimation_field        = cfg_reg[acr_pkg::DEC_LSB +: 13];
endmodule

// ### tb/acr_host.sv
// host model driving the serial link
`timescale 1ns/100ps
module acr_host (
	// link outputs
	output logic      serial_clk,
	output logic      chip_select_n,
	output logic      host_data,
	// data pins seen
	input  wire logic shared_data_in,
	input  wire logic dedicated_output_pin,
	input  wire logic dedicated_output_oe
);
	initial {serial_clk, chip_select_n, host_data} = 3'h2;
	// instruction then bytes; read bits taken just before each rise
	task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, output logic [31:0] rd);
		int          n;
		logic [39:0] sh;
		n = 8 * (ins[6:5] + 1);
		sh = {ins, wd << (32 - n)};
		rd = '0;
		chip_select_n = 1'b0;
		for (int i = 0; i < n + 8; i++) begin
			// released line toggles so a stale bit is never read as data
			#31 host_data = (ins[7] && i > 7) ? ~host_data : sh[39 - i];
			#31.5 if (i > 7) rd = {rd[30:0], dedicated_output_oe ? dedicated_output_pin : shared_data_in};
			serial_clk = 1'b1;
			#62.5 serial_clk = 1'b0;
		end
		#62.5 chip_select_n = 1'b1;
		#250;
	endtask
endmodule

// ### tb/acr_config_monitor.sv
// assertion checker for the configuration block
`timescale 1ns/100ps
module acr_config_monitor (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// inputs watched
	input wire logic        chip_select_n,
	input wire logic        result_ready_n,
	input wire logic        action_done,
	// outputs watched
	input wire logic        shared_data_oe,
	input wire logic        dedicated_output_oe,
	input wire logic        modulator_resync,
	input wire logic        result_valid,
	input wire logic [2:0]  operating_mode_field,
	input wire logic [12:0] decimation_field
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_idle;
		chip_select_n [*8];
	endsequence
	sequence s_pulse;
		modulator_resync ##1 !modulator_resync;
	endsequence
	logic temp_mode;
	assign temp_mode = !(operating_mode_field inside {3'h0, 3'h5, 3'h6});
	a_oe_exclusive: assert property (!(shared_data_oe && dedicated_output_oe))
		else $error("both data pins driven");
	a_idle_quiet: assert property (s_idle |-> !shared_data_oe && !dedicated_output_oe)
		else $error("pin driven outside frame");
	a_resync_pulse: assert property ($rose(modulator_resync) |-> s_pulse)
		else $error("resync not one cycle");
	a_resync_frame: assert property ($rose(modulator_resync) |-> !$past(chip_select_n, 3))
		else $error("resync outside frame");
	a_cfg_frame: assert property (!$stable(decimation_field) |-> !$past(chip_select_n, 3))
		else $error("config changed outside frame");
	a_mode_return: assert property (action_done && temp_mode |-> ##[1:3] operating_mode_field == 3'h0)
		else $error("temporary mode kept");
	a_mode_keep: assert property (action_done && !temp_mode && chip_select_n |=> $stable(operating_mode_field))
		else $error("permanent mode left");
	a_valid_drop: assert property ($fell(result_valid) |-> !$past(chip_select_n, 3))
		else $error("valid dropped outside write");
	a_valid_rise: assert property ($rose(result_valid) |-> !result_ready_n)
		else $error("valid rose without ready");
endmodule
bind acr_config acr_config_monitor u_mon (.*);

// ### tb/acr_config_tb.sv
// self-checking bench for the configuration register block
`timescale 1ns/100ps
module acr_config_tb;
	logic        mclk, reset_n, result_ready_n, result_load, action_done;
	logic [23:0] raw_result;
	logic [31:0] rd;
	int          n_fail, comparisons, n_resync, n_shared;
	wire         serial_clk, chip_select_n, host_data, shared_data_out, shared_data_oe;
	wire         dedicated_output_pin, dedicated_output_oe, modulator_resync, result_valid;
	wire         bias_enable, reference_output_enable;
	wire [2:0]   operating_mode_field, gain_field, rate_multiplier_field;
	wire [1:0]   channel_field;
	wire [12:0]  decimation_field;
	wire         shared_data_in = shared_data_oe ? shared_data_out : host_data;
	acr_config DUT (.*);
	acr_host u_host (.*);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic xfer(input logic rw, input logic [1:0] nb, input logic [3:0] a, input logic [31:0] d);
		u_host.xfer({rw, nb, 1'b0, a}, d, rd);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic t_reset;
		xfer(1'b1, 2'h3, 4'h4, 32'h0);
		check("reset cfg", rd, 32'h4100_0017);
		check("ref bias", {bias_enable, reference_output_enable}, 2'h1);
	endtask
	task automatic t_write;
		int s;
		xfer(1'b0, 2'h3, 4'h4, 32'h83a6_204d);
		check("resync", n_resync, 1);
		check("fields", {bias_enable, reference_output_enable, gain_field, channel_field,
			rate_multiplier_field}, 10'h231);
		s = n_shared;
		xfer(1'b1, 2'h3, 4'h4, 32'h0);
		check("readback", rd, 32'h83a6_204d);
		check("shared idle", n_shared - s, 0);
		xfer(1'b0, 2'h0, 4'h8, 32'h0);
		check("unmapped write", {bias_enable, gain_field}, 4'h9);
		xfer(1'b0, 2'h0, 4'h4, 32'h8e);
		xfer(1'b1, 2'h1, 4'h7, 32'h0);
		check("reversed", rd, 32'hb204);
	endtask
	task automatic t_result;
		logic [7:0]  top [5] = '{8'ha2, 8'h92, 8'h82, 8'ha2, 8'ha2};
		logic [23:0] raw [5] = '{24'h80_0000, 24'h80_0000, 24'h80_0000, 24'h7f_ffff, 24'h12_3456};
		logic [23:0] want [5] = '{24'h0, 24'h0, 24'h80_0000, 24'hff_ffff, 24'h92_3456};
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, 2'h0, 4'h4, {24'h0, top[i]});
			tick(1);
			{raw_result, result_load} = {raw[i], 1'b1};
			tick(1);
			result_load = 1'b0;
			xfer(1'b1, 2'h2, 4'h0, 32'h0);
			check("result", rd, want[i]);
		end
		check("dec kept", decimation_field, 13'h004d);
	endtask
	task automatic t_mode;
		for (int m = 0; m < 7; m++) begin
			xfer(1'b0, 2'h0, 4'h5, {24'h0, m[2:0], 5'h06});
			check("mode", operating_mode_field, m);
			tick(1);
			action_done = 1'b1;
			tick(1);
			action_done = 1'b0;
			tick(3);
			check("mode after", operating_mode_field, (m == 0 || m > 4) ? m : 0);
		end
	endtask
	task automatic t_chan;
		xfer(1'b0, 2'h0, 4'h5, 32'h07);
		for (int k = 0; k < 3; k++) begin
			check("invalid", result_valid, 1'h0);
			tick(1);
			result_ready_n = 1'b0;
			xfer(1'b1, 2'h0, 4'h4, 32'h0);
			check("ready bit", rd, 32'ha2);
			tick(1);
			result_ready_n = 1'b1;
			tick(10);
		end
		check("valid", result_valid, 1'h1);
	endtask
	always @(posedge mclk) begin
		n_resync += (modulator_resync === 1'b1);
		n_shared += (shared_data_oe === 1'b1);
	end
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		summarize;
	end
	initial begin
		{reset_n, result_ready_n, result_load, action_done, raw_result} = {2'h1, 26'h0};
		tick(3);
		reset_n = 1'b1;
		tick(4);
		t_reset;
		t_write;
		t_result;
		t_mode;
		t_chan;
		summarize;
	end
endmodule
